// ===== design/adm_pkg.sv
// Purpose: shared constants for the adc result dma tail and its events
// Assumes: apb slave, 32-bit data, byte addresses equal printed offsets
// Notes:   the current address reset value places the pointer at ram base
package adm_pkg;
  // register byte addresses
  localparam logic [15:0] ADDR_EVENT_PENDING   = 16'ha810;
  localparam logic [15:0] ADDR_EVENT_ENABLE    = 16'ha850;
  localparam logic [15:0] ADDR_DMA_CONTROL     = 16'hd010;
  localparam logic [15:0] ADDR_DMA_STATUS      = 16'hd014;
  localparam logic [15:0] ADDR_BUFFER_START    = 16'hd018;
  localparam logic [15:0] ADDR_BUFFER_LENGTH   = 16'hd01c;
  localparam logic [15:0] ADDR_WRITE_POINTER   = 16'hd020;
  localparam logic [15:0] ADDR_RESULTS_STORED  = 16'hd024;
  // field positions
  localparam int          BIT_OVERFLOW_EVENT   = 4;
  localparam int          BIT_SATURATION_EVENT = 3;
  localparam int          BIT_FULL_EVENT       = 2;
  localparam int          BIT_HALF_EVENT       = 1;
  localparam int          BIT_DMA_RESET        = 4;
  localparam int          BIT_WRAP_MODE        = 1;
  localparam int          BIT_LOAD_REQUEST     = 0;
  localparam int          BIT_OVERFLOW_STATUS  = 1;
  localparam int          BIT_DMA_ACTIVE       = 0;
  // widths
  localparam int          COUNT_W              = 13;
  localparam int          ADDR_W               = 14;
  // reset values
  localparam logic [31:0] RESET_WRITE_POINTER  = 32'h2000_0000;
  localparam logic [ADDR_W-1:0] RESET_START    = 14'h0000;
  localparam logic [4:0]  EVENT_MASK           = 5'h1e;
  // dma engine states, gray along idle -> run -> stop
  typedef enum logic [1:0] {
    ADM_IDLE = 2'b00,
    ADM_RUN  = 2'b01,
    ADM_STOP = 2'b11
  } adm_state_t;
endpackage : adm_pkg

// ===== design/adm_event_bit.sv
// Purpose: one sticky event flag with write-one-to-clear and enable gate
// Assumes: set and clear are single-cycle strobes
// Notes:   a set in the clear cycle wins, so no event is lost
`timescale 1ns/1ps
module adm_event_bit (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic set_evt,
  input  wire logic clr_evt,
  input  wire logic wr_en,
  input  wire logic en_val,
  output logic      pend,
  output logic      en,
  output logic      req
);
  // state of one flag
  typedef struct packed {
    logic pend;
    logic en;
  } adm_bit_t;
  adm_bit_t s_reg;
  adm_bit_t s_next;

  // next flag: set beats clear
  always_comb begin
    s_next      = s_reg;
    if (clr_evt) begin
      s_next.pend = 1'b0;
    end
    if (set_evt) begin
      s_next.pend = 1'b1;
    end
    if (wr_en) begin
      s_next.en = en_val;
    end
  end

  // registered flag
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pend = s_reg.pend;
  assign en   = s_reg.en;
  assign req  = s_reg.pend & s_reg.en;
endmodule : adm_event_bit

// ===== design/adm_result_dma.sv
// Purpose: adc result buffer dma tail, its registers and interrupt line
// Assumes: apb slave; results arrive as one-cycle strobes with data
// Notes:   one ram write per result stored in run, ram must accept in the same cycle
`timescale 1ns/1ps
module adm_result_dma (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // conversion path
  input  wire logic        result_valid,
  input  wire logic [15:0] result_data,
  input  wire logic        gain_saturated,
  // ram write port
  output logic             ram_we,
  output logic [13:0]      ram_addr,
  output logic [15:0]      ram_wdata,
  // top-level interrupt line
  output logic             irq
);
  // state layout notes:
  //   st         dma engine phase, gray coded
  //   wrap       auto-wrap mode select, software owned
  //   load       transfer load request, set by software, cleared by hardware
  //   ovf_status overflow status, cleared only by a dma reset
  //   start      buffer start address, bit 0 always zero
  //   length     buffer length in results, not bytes
  //   cur        next ram byte address the engine writes
  //   count      results stored since the last load, wrap or dma reset
  //   the rest   registered apb answer, ram write and interrupt line
  //   all fields live in one packed struct, filled by one combinational
  //   process and registered by one clocked process
  // whole block state
  typedef struct packed {
    adm_pkg::adm_state_t          st;
    logic                         wrap;
    logic                         load;
    logic                         ovf_status;
    logic [adm_pkg::ADDR_W-1:0]   start;
    logic [adm_pkg::COUNT_W-1:0]  length;
    logic [adm_pkg::ADDR_W-1:0]   cur;
    logic [adm_pkg::COUNT_W-1:0]  count;
    logic                         pready;
    logic [31:0]                  prdata;
    logic                         pslverr;
    logic                         ram_we;
    logic [13:0]                  ram_addr;
    logic [15:0]                  ram_wdata;
    logic                         irq;
  } adm_state_all_t;
  adm_state_all_t s_reg;
  adm_state_all_t s_next;

  // the strobes below are combinational decodes of the bus and the
  // result port; they feed the next-state logic and the flag cells
  // only, never an output
  // event strobes and register wiring
  logic       access;              // apb access phase
  logic       wr;                  // write strobe this cycle
  logic [4:0] ev_set;              // hardware events
  logic [4:0] ev_pend;             // pending flags
  logic [4:0] ev_en;               // enables
  logic [4:0] ev_req;              // enabled and pending
  logic       pend_wr;             // pending register write
  logic       en_wr;               // enable register write
  logic       stored;              // result taken into ram this cycle
  logic       ovf_hit;             // result while dma inactive
  logic       half_hit;            // count reaches half
  logic       full_hit;            // count reaches length
  logic [adm_pkg::COUNT_W-1:0] cnt_inc; // count after this result

  assign access   = psel & penable;
  assign wr       = access & pwrite;
  // one strobe per transfer: a second clear in the answer cycle would eat a fresh event
  assign pend_wr  = wr & ~s_reg.pready & (paddr == adm_pkg::ADDR_EVENT_PENDING);
  assign en_wr    = wr & ~s_reg.pready & (paddr == adm_pkg::ADDR_EVENT_ENABLE);
  assign stored   = result_valid & (s_reg.st == adm_pkg::ADM_RUN);
  assign ovf_hit  = result_valid & (s_reg.st != adm_pkg::ADM_RUN);
  assign cnt_inc  = s_reg.count + 13'h0001;
  assign half_hit = stored & (cnt_inc == (s_reg.length >> 1)) & (s_reg.length > 13'h0001);
  assign full_hit = stored & (cnt_inc == s_reg.length);

  // event sources:
  //   overflow   a result arrives while the engine is idle or stopped
  //   saturation pulse from the gain stage, taken as it comes
  //   full       the stored count reaches the programmed length
  //   half       the stored count reaches half the length
  //   half is suppressed for lengths of 0 and 1, where no half exists
  //   every source is a single-cycle strobe; the flag cell makes it sticky
  //   bit 0 carries no event and stays low
  // event bit vector, bit 0 unused
  always_comb begin
    ev_set                                 = 5'h00;
    ev_set[adm_pkg::BIT_OVERFLOW_EVENT]    = ovf_hit;
    ev_set[adm_pkg::BIT_SATURATION_EVENT]  = gain_saturated;
    ev_set[adm_pkg::BIT_FULL_EVENT]        = full_hit;
    ev_set[adm_pkg::BIT_HALF_EVENT]        = half_hit;
  end

  // flag cells:
  //   bit 0 is reserved in both registers and reads back as zero
  //   a write-one clears a flag; an event in that same cycle wins
  //   the enable write loads all four enables at once
  //   clear and enable writes use the first access cycle only
  //   a write of zero to a flag leaves it untouched
  // one flag cell per event, bit 0 tied off
  assign ev_pend[0] = 1'b0;
  assign ev_en[0]   = 1'b0;
  assign ev_req[0]  = 1'b0;
  genvar gi;
  generate
    for (gi = 1; gi < 5; gi++) begin : g_evt
      adm_event_bit u_bit (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .set_evt (ev_set[gi]),
        .clr_evt (pend_wr & pwdata[gi]),
        .wr_en   (en_wr),
        .en_val  (pwdata[gi]),
        .pend    (ev_pend[gi]),
        .en      (ev_en[gi]),
        .req     (ev_req[gi])
      );
    end
  endgenerate

  // apb timing, one wait state:
  //   cycle 0  setup, psel high, penable low
  //   cycle 1  access, penable high; the edge closing it decodes the transfer
  //   cycle 2  pready and pslverr stand for this one cycle; prdata holds until the next answer
  //   the master drops penable after sampling pready
  //   the !pready term keeps a held access from being answered twice
  //   back-to-back transfers are fine: a new setup may follow pready
  // read data is captured at the decode edge, so it is a snapshot of
  // the registers one cycle before pready; a result stored in the
  // answer cycle shows up on the next read
  // writes to read-only registers are accepted silently
  // any other address answers with pslverr and changes nothing
  // next state: apb, dma engine, interrupt line
  always_comb begin
    s_next         = s_reg;
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.ram_we  = 1'b0;
    // apb answer one cycle after access phase starts
    if (access && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      unique case (paddr)
        adm_pkg::ADDR_EVENT_PENDING:  s_next.prdata[4:0] = ev_pend;
        adm_pkg::ADDR_EVENT_ENABLE:   s_next.prdata[4:0] = ev_en;
        adm_pkg::ADDR_DMA_CONTROL: begin
          s_next.prdata[adm_pkg::BIT_WRAP_MODE]    = s_reg.wrap;
          s_next.prdata[adm_pkg::BIT_LOAD_REQUEST] = s_reg.load;
        end
        adm_pkg::ADDR_DMA_STATUS: begin
          s_next.prdata[adm_pkg::BIT_OVERFLOW_STATUS] = s_reg.ovf_status;
          s_next.prdata[adm_pkg::BIT_DMA_ACTIVE]      = (s_reg.st == adm_pkg::ADM_RUN);
        end
        adm_pkg::ADDR_BUFFER_START:   s_next.prdata[13:0] = s_reg.start;
        adm_pkg::ADDR_BUFFER_LENGTH:  s_next.prdata[12:0] = s_reg.length;
        adm_pkg::ADDR_WRITE_POINTER:  s_next.prdata = adm_pkg::RESET_WRITE_POINTER
                                                      | {18'h00000, s_reg.cur};
        adm_pkg::ADDR_RESULTS_STORED: s_next.prdata[12:0] = s_reg.count;
        default:                      s_next.pslverr = 1'b1;
      endcase
      if (pwrite) begin
        s_next.prdata = 32'h0000_0000;
        unique case (paddr)
          adm_pkg::ADDR_DMA_CONTROL: begin
            s_next.wrap = pwdata[adm_pkg::BIT_WRAP_MODE];
            if (pwdata[adm_pkg::BIT_LOAD_REQUEST]) begin
              s_next.load = 1'b1;
            end
          end
          adm_pkg::ADDR_BUFFER_START:  s_next.start  = {pwdata[13:1], 1'b0};
          adm_pkg::ADDR_BUFFER_LENGTH: s_next.length = pwdata[12:0];
          adm_pkg::ADDR_EVENT_PENDING,
          adm_pkg::ADDR_EVENT_ENABLE,
          adm_pkg::ADDR_DMA_STATUS,
          adm_pkg::ADDR_WRITE_POINTER,
          adm_pkg::ADDR_RESULTS_STORED: s_next.pslverr = 1'b0;
          default:                      s_next.pslverr = 1'b1;
        endcase
      end
    end
    // engine phases:
    //   idle  after reset or a dma reset; waits for a load request
    //   run   each result is written to ram at cur, cur moves on by
    //         two bytes and count by one
    //   stop  linear mode after the last result of the buffer; cur is
    //         back at start and count holds the length until a reload or a dma reset
    //   wrap mode never stops: cur returns to start, count to zero
    //   outside run every result is lost and raises overflow
    //   a load in idle or stop restarts from the start address
    //   a load written while running waits until the engine stops
    // dma engine
    unique case (s_reg.st)
      adm_pkg::ADM_IDLE,
      adm_pkg::ADM_STOP: begin
        // overflow when a result finds dma inactive
        if (ovf_hit) begin
          s_next.ovf_status = 1'b1;
        end
        if (s_reg.load) begin
          s_next.st    = adm_pkg::ADM_RUN;
          s_next.load  = 1'b0;
          s_next.cur   = s_reg.start;
          s_next.count = 13'h0000;
        end
      end
      adm_pkg::ADM_RUN: begin
        if (stored) begin
          s_next.ram_we    = 1'b1;
          s_next.ram_addr  = s_reg.cur;
          s_next.ram_wdata = result_data;
          s_next.cur       = s_reg.cur + 14'h0002;
          s_next.count     = cnt_inc;
          if (full_hit) begin
            s_next.cur = s_reg.start;
            if (s_reg.wrap) begin
              s_next.count = 13'h0000;
            end else begin
              s_next.st = adm_pkg::ADM_STOP;
            end
          end
        end
      end
      default: s_next.st = adm_pkg::ADM_IDLE;
    endcase
    // the dma reset comes last so that it overrides the engine and any
    // load written in the same transfer; an overflow raised in that very
    // cycle still survives, so no event is lost
    // flags in the event register are not touched by a dma reset
    // dma reset: back to idle, clear load and overflow status
    if (wr && !s_reg.pready && paddr == adm_pkg::ADDR_DMA_CONTROL
        && pwdata[adm_pkg::BIT_DMA_RESET]) begin
      s_next.st         = adm_pkg::ADM_IDLE;
      s_next.load       = 1'b0;
      s_next.ovf_status = ovf_hit;
      s_next.cur        = s_reg.start;
      s_next.count      = 13'h0000;
    end
    // the line is the or of all enabled flags; it lags the flags by
    // one cycle because it is registered
    // software masks the whole peripheral only at the top level
    // single peripheral line from all enabled flags
    s_next.irq = |ev_req;
  end

  // every field resets to zero except the engine phase and the two
  // addresses, which take their package reset values
  // the reset branch assigns constants only
  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_reg       <= '0;
      s_reg.st    <= adm_pkg::ADM_IDLE;
      s_reg.start <= adm_pkg::RESET_START;
      s_reg.cur   <= adm_pkg::RESET_START;
    end else begin
      s_reg <= s_next;
    end
  end

  // each output below is a field of the state register, so none of
  // them carries combinational logic from the inputs
  // pready, pslverr and ram_we are single-cycle pulses
  // outputs straight from flops
  assign pready    = s_reg.pready;
  assign prdata    = s_reg.prdata;
  assign pslverr   = s_reg.pslverr;
  assign ram_we    = s_reg.ram_we;
  assign ram_addr  = s_reg.ram_addr;
  assign ram_wdata = s_reg.ram_wdata;
  assign irq       = s_reg.irq;
endmodule : adm_result_dma

// ===== sim/adm_ram_model.sv
// Purpose: ram beside the dma tail, records every write it takes
// Assumes: write accepted in the cycle ram_we is high
// Notes:   keeps last address, last data and a write count
`timescale 1ns/1ps
module adm_ram_model (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ram_we,
  input  wire logic [13:0] ram_addr,
  input  wire logic [15:0] ram_wdata,
  output logic      [13:0] last_addr,
  output logic      [15:0] last_data,
  output int               wr_count
);
  // capture each accepted write
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      last_addr <= 14'h0;
      last_data <= 16'h0;
      wr_count  <= 0;
    end else if (ram_we) begin
      last_addr <= ram_addr;
      last_data <= ram_wdata;
      wr_count  <= wr_count + 1;
    end
  end
endmodule : adm_ram_model

// ===== sim/adm_result_dma_properties.sv
// Purpose: port checks of the result dma tail
// Assumes: apb answer one cycle after the access phase starts
// Notes:   bound to every adm_result_dma instance
`timescale 1ns/1ps
module adm_props (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        result_valid,
  input wire logic [15:0] result_data,
  input wire logic        ram_we,
  input wire logic [13:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  input wire logic        irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // first cycle of an access phase
  sequence acc_s;
    psel && $rose(penable);
  endsequence
  ready_delay_a: assert property (acc_s |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0) else $error("write data");
  unmapped_err_a: assert property (acc_s ##0 paddr[15:12] == 4'h0 |=> pslverr) else $error("no pslverr");
  ram_cause_a: assert property (ram_we |-> $past(result_valid)) else $error("stray ram write");
  ram_even_a: assert property (ram_we |-> !ram_addr[0]) else $error("odd ram address");
  ram_data_a: assert property (ram_we |-> ram_wdata == $past(result_data)) else $error("ram data");
  irq_fall_a: assert property ($fell(irq) |-> $past(pwrite && penable) || $past(pwrite && penable, 2))
    else $error("irq fell alone");
endmodule : adm_props
bind adm_result_dma adm_props u_props (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .result_valid(result_valid), .result_data(result_data), .ram_we(ram_we), .ram_addr(ram_addr),
  .ram_wdata(ram_wdata), .irq(irq));

// ===== sim/tb_adc_result_dma_and_irq.sv
// Purpose: self-checking bench of the result dma tail
// Assumes: apb master waits for pready, results one per pulse
// Notes:   ram model records writes
`timescale 1ns/1ps
module tb_adc_result_dma_and_irq;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, rv, sat, ram_we, irq;
  logic [15:0] paddr, rdat, ram_wdata, l_data;
  logic [31:0] pwdata, prdata;
  logic [13:0] ram_addr, l_addr;
  int          wr_count, err_count, total_checks, i, n;
  adm_result_dma DUT (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .result_valid(rv),
    .result_data(rdat), .gain_saturated(sat), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .irq(irq));
  adm_ram_model ram (.clk_sys(clk_sys), .resetn(resetn), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .last_addr(l_addr), .last_data(l_data), .wr_count(wr_count));
  // 250 mhz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, q, exp);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  // one result or saturation pulse
  task automatic send(input logic s, input logic [15:0] d);
    @(posedge clk_sys);
    if (s) sat <= 1'b1;
    else rv <= 1'b1;
    rdat <= d;
    @(posedge clk_sys);
    rv  <= 1'b0;
    sat <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : send
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rd(adm_pkg::ADDR_EVENT_PENDING, 32'h0, "pending");
    rd(adm_pkg::ADDR_EVENT_ENABLE, 32'h0, "enable");
    rd(adm_pkg::ADDR_BUFFER_LENGTH, 32'h0, "length");
    rd(adm_pkg::ADDR_WRITE_POINTER, 32'h2000_0000, "pointer");
    rd(adm_pkg::ADDR_RESULTS_STORED, 32'h0, "count");
    apb(1'b0, 16'h0004, 32'h0, q, e);
    check("unmapped", {31'h0, e}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_linear();
    wr(adm_pkg::ADDR_BUFFER_START, 32'h0000_0101);
    rd(adm_pkg::ADDR_BUFFER_START, 32'h0000_0100, "start");
    wr(adm_pkg::ADDR_BUFFER_LENGTH, 32'hffff_e004);
    rd(adm_pkg::ADDR_BUFFER_LENGTH, 32'h4, "length");
    wr(adm_pkg::ADDR_DMA_CONTROL, 32'h1);
    rd(adm_pkg::ADDR_DMA_CONTROL, 32'h0, "load");
    for (i = 0; i < 4; i++) begin
      rd(adm_pkg::ADDR_WRITE_POINTER, 32'h2000_0100 + 2 * i, "pointer");
      send(1'b0, 16'ha500 + 16'(i));
      check("ram addr", {18'h0, l_addr}, 32'h100 + 2 * i);
      check("ram data", {16'h0, l_data}, 32'ha500 + i);
      rd(adm_pkg::ADDR_RESULTS_STORED, i + 1, "count");
    end
    rd(adm_pkg::ADDR_WRITE_POINTER, 32'h2000_0100, "pointer");
    rd(adm_pkg::ADDR_EVENT_PENDING, 32'h6, "pending");
    n = wr_count;
    send(1'b0, 16'h1234);
    check("no write", wr_count, n);
    rd(adm_pkg::ADDR_EVENT_PENDING, 32'h16, "pending");
    rd(adm_pkg::ADDR_DMA_STATUS, 32'h2, "status");
    check("irq", {31'h0, irq}, 32'h0);
    wr(adm_pkg::ADDR_EVENT_ENABLE, 32'h10);
    repeat (3) @(posedge clk_sys);
    check("irq", {31'h0, irq}, 32'h1);
    wr(adm_pkg::ADDR_EVENT_PENDING, 32'h11);
    repeat (3) @(posedge clk_sys);
    check("irq", {31'h0, irq}, 32'h0);
    rd(adm_pkg::ADDR_EVENT_PENDING, 32'h6, "pending");
    wr(adm_pkg::ADDR_DMA_CONTROL, 32'h10);
    rd(adm_pkg::ADDR_DMA_STATUS, 32'h0, "status");
    $display("test linear done");
  endtask : t_linear
  task automatic t_sat_wrap();
    wr(adm_pkg::ADDR_EVENT_PENDING, 32'h17);
    wr(adm_pkg::ADDR_EVENT_ENABLE, 32'h02);
    send(1'b1, 16'h0);
    rd(adm_pkg::ADDR_EVENT_PENDING, 32'h8, "pending");
    check("irq", {31'h0, irq}, 32'h0);
    wr(adm_pkg::ADDR_EVENT_ENABLE, 32'h08);
    repeat (3) @(posedge clk_sys);
    check("irq", {31'h0, irq}, 32'h1);
    wr(adm_pkg::ADDR_BUFFER_LENGTH, 32'h2);
    wr(adm_pkg::ADDR_DMA_CONTROL, 32'h3);
    for (i = 0; i < 3; i++) send(1'b0, 16'h0);
    check("wrap addr", {18'h0, l_addr}, 32'h100);
    rd(adm_pkg::ADDR_RESULTS_STORED, 32'h1, "count");
    rd(adm_pkg::ADDR_DMA_CONTROL, 32'h2, "control");
    $display("test sat wrap done");
  endtask : t_sat_wrap
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    {resetn, psel, penable, pwrite, rv, sat} = 6'h0;
    paddr  = 16'h0;
    pwdata = 32'h0;
    rdat   = 16'h0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_linear();
    t_sat_wrap();
    report_and_stop();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end
endmodule : tb_adc_result_dma_and_irq
